// [mst_pkg.sv]
// mst_pkg: shared types and constants for measured-value scaling and
// bus time synchronisation.
// assumes a single 20 MHz device clock; no timescale in packages.
package mst_pkg;
  // clock and supervision timing
  localparam int CLK_HZ = 20000000;
  localparam int SUP_TIME_MS = 65000;
  localparam int SUP_CYCLES_DEF = SUP_TIME_MS * (CLK_HZ / 1000);
  localparam int SUP_CNT_W = 32;

  // time/date transfer block: words, trigger index and trigger command
  localparam int TD_WORDS = 4;
  localparam logic [2:0] TD_FIRST_IDX = 3'h0;
  localparam logic [2:0] TRIG_IDX = 3'h4;
  localparam logic [15:0] TRIG_CMD = 16'hFFFF;
  localparam logic [15:0] TRIG_READ_VAL = 16'h0000;
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_ILLEGAL_ADDR = 8'h02;

  // scaling: inputs are fixed point with four decimal fraction digits
  localparam logic signed [31:0] ZERO_OFFSET = 32'sh0;
  localparam logic [3:0] IDX_LAST_BASE = 4'h6;
  localparam logic [3:0] IDX_LAST_EXT = 4'h9;
  localparam logic signed [31:0] SAT_MAX = 32'sh0000_7FFF;
  localparam logic signed [31:0] SAT_MIN = -32'sh0000_8000;

  // nominal-value thresholds, currents in units of 0.01 A
  localparam logic [31:0] TH_1A = 32'h0000_0064;
  localparam logic [31:0] TH_10A = 32'h0000_03E8;
  localparam logic [31:0] TH_100A = 32'h0000_2710;
  localparam logic [31:0] TH_1KA = 32'h0001_86A0;
  localparam logic [31:0] TH_10KA = 32'h000F_4240;
  // power thresholds in units of 0.0001 kW
  localparam logic [47:0] TH_100KW = 48'h0000_000F_4240;
  localparam logic [47:0] TH_1MW = 48'h0000_0098_9680;
  localparam logic [47:0] TH_10MW = 48'h0000_05F5_E100;
  localparam logic [47:0] TH_100MW = 48'h0000_3B9A_CA00;
  localparam logic [47:0] TH_1GW = 48'h0002_540B_E400;
  localparam logic [47:0] TH_10GW = 48'h0017_4876_E800;
  localparam logic [15:0] SQRT3_Q15 = 16'hDDB4;

  typedef enum logic [1:0] {VT_PRIMARY, VT_SECONDARY, VT_PERCENT} mst_vtype_t;

  // unit as power of ten of the base unit, plus fraction digits
  typedef struct packed {
    logic signed [3:0] unit_exp;
    logic [1:0] frac;
  } mst_fmt_t;

  typedef struct packed {
    logic signed [31:0] primary;
    logic signed [31:0] secondary;
    logic signed [31:0] percent;
  } mst_meas_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic bcast;
    logic multi;
    logic [2:0] start;
    logic [2:0] count;
    logic [TD_WORDS-1:0][15:0] data;
  } mst_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] exc;
    logic [TD_WORDS-1:0][15:0] data;
  } mst_rsp_t;
endpackage

// [mst_core.sv]
// mst_core: measured-value scaling, number-format selection and
// bus time/date acceptance with sync supervision.
// assumes all inputs come from logic on clk; link layer decodes frames.
//
// Contract
// - indices 0-6 give fixed type and factor
// - indices 7-9 secondary, optional per variant
// - phase current digits follow nominal current
// - ground current digits follow ground rating
// - power digits follow voltage times current root3
// - direct mode applies full broadcast write
// - direct mode rejects partial writes, code 02
// - direct mode trigger access gives code 02
// - trigger mode stages transfer-register writes
// - broadcast FFFF to trigger applies staged time
// - trigger register always reads zero
// - transfer reads return last written values
// - every valid sync restarts supervision timer
// - timer expiry raises clock sync fault
// - integer equals value times factor plus offset
// - scaled value sent as two bytes
`timescale 1ns/1ns
module mst_core
#(
  parameter bit HAS_SEC_EXT = 1'b1,
  parameter int SUP_CYCLES = mst_pkg::SUP_CYCLES_DEF
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic meas_valid,
  input wire mst_pkg::mst_meas_t meas_in,
  input wire logic [3:0] scale_index,
  input wire logic [23:0] nom_volt_c,
  input wire logic [23:0] nom_curr_c,
  input wire logic [31:0] gnd_rating_c,
  input wire logic direct_mode,
  input wire mst_pkg::mst_req_t req,
  output mst_pkg::mst_rsp_t rsp,
  output logic scaled_valid,
  output logic [15:0] scaled_value,
  output logic scale_err,
  output mst_pkg::mst_fmt_t curr_fmt,
  output mst_pkg::mst_fmt_t gnd_fmt,
  output mst_pkg::mst_fmt_t pwr_fmt,
  output logic sync_pulse,
  output logic [mst_pkg::TD_WORDS-1:0][15:0] clock_time,
  output logic clock_sync_fault
);
  import mst_pkg::*;

  // divisor that turns 4-digit fixed point into value times factor
  function automatic logic signed [31:0] idx_div(input logic [3:0] idx);
    unique case (idx)
      4'h0, 4'h7: idx_div = 32'sh0000_2710; // factor 1
      4'h1, 4'h8: idx_div = 32'sh0000_03E8; // factor 10
      4'h2, 4'h6, 4'h9: idx_div = 32'sh0000_0064; // factor 100
      4'h3, 4'h5: idx_div = 32'sh0000_000A; // factor 1000
      default: idx_div = 32'sh0000_0001; // factor 10000
    endcase
  endfunction

  function automatic mst_fmt_t mk_fmt(input logic signed [3:0] e,
                                      input logic [1:0] f);
    mk_fmt.unit_exp = e;
    mk_fmt.frac = f;
  endfunction

  // scaling path: type select, factor, offset, saturation
  logic idx_ok;
  mst_vtype_t vtype;
  logic signed [31:0] src_val;
  logic signed [31:0] prod;
  logic signed [31:0] sum;
  logic next_scaled_valid;
  logic [15:0] next_scaled_value;
  logic next_scale_err;
  always_comb
  begin
    idx_ok = (scale_index <= IDX_LAST_BASE) ||
             (HAS_SEC_EXT && scale_index <= IDX_LAST_EXT);
    if (scale_index <= 4'h4)
      vtype = VT_PRIMARY;
    else if (scale_index == 4'h6)
      vtype = VT_PERCENT;
    else
      vtype = VT_SECONDARY;
    unique case (vtype)
      VT_PRIMARY: src_val = meas_in.primary;
      VT_SECONDARY: src_val = meas_in.secondary;
      VT_PERCENT: src_val = meas_in.percent;
    endcase
    prod = src_val / idx_div(scale_index);
    sum = prod + ZERO_OFFSET;
    next_scaled_valid = meas_valid;
    next_scale_err = meas_valid && !idx_ok;
    if (!meas_valid || !idx_ok)
      next_scaled_value = scaled_value;
    else if (sum > SAT_MAX)
      next_scaled_value = 16'h7FFF;
    else if (sum < SAT_MIN)
      next_scaled_value = 16'h8000;
    else
      next_scaled_value = sum[15:0];
  end

  // number formats from nominal values; clamps outside the ranges
  logic [47:0] vi_prod;
  logic [63:0] pwr_raw;
  logic [47:0] pwr_e4;
  mst_fmt_t next_curr_fmt;
  mst_fmt_t next_gnd_fmt;
  mst_fmt_t next_pwr_fmt;
  always_comb
  begin
    if (nom_curr_c <= TH_100A[23:0])
      next_curr_fmt = mk_fmt(4'sh0, 2'h1);
    else if (nom_curr_c <= TH_1KA[23:0])
      next_curr_fmt = mk_fmt(4'sh0, 2'h0);
    else
      next_curr_fmt = mk_fmt(4'sh3, 2'h2);
    if (gnd_rating_c <= TH_1A)
      next_gnd_fmt = mk_fmt(-4'sh3, 2'h0);
    else if (gnd_rating_c <= TH_10A)
      next_gnd_fmt = mk_fmt(4'sh0, 2'h2);
    else if (gnd_rating_c <= TH_100A)
      next_gnd_fmt = mk_fmt(4'sh0, 2'h1);
    else if (gnd_rating_c <= TH_1KA)
      next_gnd_fmt = mk_fmt(4'sh0, 2'h0);
    else if (gnd_rating_c <= TH_10KA)
      next_gnd_fmt = mk_fmt(4'sh3, 2'h2);
    else
      next_gnd_fmt = mk_fmt(4'sh3, 2'h1);
    // q15 root three keeps the product in one multiplier chain
    // operands widened first so no partial product is cut
    vi_prod = {24'h000000, nom_volt_c} * {24'h000000, nom_curr_c};
    pwr_raw = {16'h0000, vi_prod} * {48'h0000_0000_0000, SQRT3_Q15};
    pwr_e4 = pwr_raw[62:15];
    if (pwr_e4 <= TH_100KW)
      next_pwr_fmt = mk_fmt(4'sh3, 2'h1);
    else if (pwr_e4 <= TH_1MW)
      next_pwr_fmt = mk_fmt(4'sh3, 2'h0);
    else if (pwr_e4 <= TH_10MW)
      next_pwr_fmt = mk_fmt(4'sh6, 2'h2);
    else if (pwr_e4 <= TH_100MW)
      next_pwr_fmt = mk_fmt(4'sh6, 2'h1);
    else if (pwr_e4 <= TH_1GW)
      next_pwr_fmt = mk_fmt(4'sh6, 2'h0);
    else if (pwr_e4 <= TH_10GW)
      next_pwr_fmt = mk_fmt(4'sh9, 2'h2);
    else
      next_pwr_fmt = mk_fmt(4'sh9, 2'h1);
  end

  // register the scaling outputs and formats
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      scaled_valid <= 1'b0;
      scaled_value <= 16'h0000;
      scale_err <= 1'b0;
      curr_fmt <= '0;
      gnd_fmt <= '0;
      pwr_fmt <= '0;
    end
    else
    begin
      scaled_valid <= next_scaled_valid;
      scaled_value <= next_scaled_value;
      scale_err <= next_scale_err;
      curr_fmt <= next_curr_fmt;
      gnd_fmt <= next_gnd_fmt;
      pwr_fmt <= next_pwr_fmt;
    end
  end

  // time/date request decode; one answer per request, next cycle
  logic [3:0] req_end;
  logic in_td;
  logic hits_trig;
  logic full_td;
  logic do_sync;
  logic [TD_WORDS-1:0][15:0] staged;
  logic [TD_WORDS-1:0][15:0] next_staged;
  logic [TD_WORDS-1:0][15:0] next_clock_time;
  mst_rsp_t next_rsp;
  logic [SUP_CNT_W-1:0] sup_cnt;
  logic [SUP_CNT_W-1:0] next_sup_cnt;
  logic next_fault;
  always_comb
  begin
    req_end = {1'b0, req.start} + {1'b0, req.count};
    in_td = req.count != 3'h0 && req_end <= 4'(TD_WORDS);
    hits_trig = req.start == TRIG_IDX && req.count == 3'h1;
    full_td = req.start == TD_FIRST_IDX && req.count == 3'(TD_WORDS);
    do_sync = 1'b0;
    next_staged = staged;
    next_clock_time = clock_time;
    next_rsp.valid = req.valid;
    next_rsp.exc = EXC_NONE;
    next_rsp.data = '0;
    if (req.valid)
    begin
      if (req.write && in_td)
      begin
        if (direct_mode && !(full_td && req.multi && req.bcast))
          next_rsp.exc = EXC_ILLEGAL_ADDR;
        else
        begin
          for (int i = 0; i < TD_WORDS; i++)
            if (i >= req.start && i < req_end)
              next_staged[i] = req.data[i - req.start];
          do_sync = direct_mode;
        end
      end
      else if (hits_trig && !direct_mode)
      begin
        // only a broadcast FFFF starts the sync; the value is not kept
        do_sync = req.write && req.bcast && req.data[0] == TRIG_CMD;
        next_rsp.data[0] = TRIG_READ_VAL;
      end
      else if (!req.write && in_td)
      begin
        for (int i = 0; i < TD_WORDS; i++)
          if (i < req.count)
            next_rsp.data[i] = staged[3'(i) + req.start];
      end
      else
        next_rsp.exc = EXC_ILLEGAL_ADDR;
    end
    if (do_sync)
      next_clock_time = next_staged;
    // restart on every sync; saturate at zero while faulted
    if (do_sync)
      next_sup_cnt = SUP_CNT_W'(SUP_CYCLES);
    else if (sup_cnt != '0)
      next_sup_cnt = sup_cnt - 1'b1;
    else
      next_sup_cnt = sup_cnt;
    next_fault = !do_sync && (clock_sync_fault || sup_cnt == '0);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      staged <= '0;
      clock_time <= '0;
      rsp <= '0;
      sync_pulse <= 1'b0;
      sup_cnt <= SUP_CNT_W'(SUP_CYCLES);
      clock_sync_fault <= 1'b0;
    end
    else
    begin
      staged <= next_staged;
      clock_time <= next_clock_time;
      rsp <= next_rsp;
      sync_pulse <= do_sync;
      sup_cnt <= next_sup_cnt;
      clock_sync_fault <= next_fault;
    end
  end

  // checks on the design's own outputs
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_sat_high: assert property (meas_valid && idx_ok && sum > SAT_MAX
    |=> scaled_value == 16'h7FFF) else $error("no high saturation");
  a_sat_low: assert property (meas_valid && idx_ok && sum < SAT_MIN
    |=> scaled_value == 16'h8000) else $error("no low saturation");
  a_idx_err: assert property (meas_valid && scale_index > IDX_LAST_EXT
    |=> scale_err) else $error("bad index accepted");
  a_direct_partial: assert property (req.valid && req.write && direct_mode
    && in_td && !full_td |=> rsp.exc == EXC_ILLEGAL_ADDR && !sync_pulse)
    else $error("partial direct write taken");
  a_direct_trig: assert property (req.valid && direct_mode && hits_trig
    |=> rsp.valid && rsp.exc == EXC_ILLEGAL_ADDR)
    else $error("trigger exists in direct mode");
  a_trig_zero: assert property (req.valid && !direct_mode && hits_trig
    |=> rsp.data[0] == 16'h0000 && rsp.exc == EXC_NONE)
    else $error("trigger read not zero");
  a_trig_sync: assert property (req.valid && req.write && req.bcast &&
    !direct_mode && hits_trig && req.data[0] == TRIG_CMD
    |=> sync_pulse && clock_time == $past(staged))
    else $error("trigger did not sync");
  a_stage_only: assert property (req.valid && req.write && !direct_mode &&
    in_td |=> !sync_pulse && $stable(clock_time))
    else $error("staged write applied");
  a_direct_sync: assert property (req.valid && req.write && req.bcast &&
    req.multi && direct_mode && full_td |=> sync_pulse ##0
    clock_time == $past(req.data)) else $error("direct sync lost");
  a_sup_restart: assert property (sync_pulse |-> !clock_sync_fault ##0
    sup_cnt == SUP_CNT_W'(SUP_CYCLES)) else $error("timer not reset");
  a_fault_raise: assert property (sup_cnt == '0 && !do_sync
    |=> clock_sync_fault) else $error("fault not raised");

  c_direct: cover property (sync_pulse && direct_mode);
  c_trigger: cover property (sync_pulse && !direct_mode);
  c_fault: cover property (clock_sync_fault);
  c_saturate: cover property (scaled_valid && scaled_value == 16'h7FFF);
endmodule // mst_core

// [mst_master.sv]
// mst_master: bus master model that issues time/date requests.
// assumes the device takes req on the rising clk edge, answers next cycle.
`timescale 1ns/1ns
module mst_master
(
  input wire logic clk,
  output mst_pkg::mst_req_t req,
  input wire mst_pkg::mst_rsp_t rsp
);
  import mst_pkg::*;

  initial req = '0;

  // one request pulse; broadcast full writes carry direct time
  // callers may leave gaps longer than the supervision span between syncs
  task automatic xfer(input logic w, b, m, input logic [2:0] s, c,
    input logic [63:0] d, output mst_rsp_t r);
    @(negedge clk);
    req <= {1'b1, w, b, m, s, c, d};
    @(negedge clk);
    r = rsp;
    // released data is scrambled, so stale words cannot pass as good
    req <= {1'b0, ~w, ~b, ~m, ~s, ~c, ~d};
  endtask
endmodule // mst_master

// [test_meas_scaling_time_sync.sv]
// test bench: scaling, number formats, time sync and supervision.
// assumes mst_core with a short supervision count of 20 cycles.
`timescale 1ns/1ns
module test_meas_scaling_time_sync;
  import mst_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic meas_valid = 1'b0;
  mst_meas_t meas_in = '0;
  logic [3:0] scale_index = 4'h0;
  logic [23:0] nom_volt_c = 24'h0;
  logic [23:0] nom_curr_c = 24'h0;
  logic [31:0] gnd_rating_c = 32'h0;
  logic direct_mode = 1'b0;
  mst_req_t req;
  mst_rsp_t rsp;
  mst_rsp_t r;
  logic scaled_valid, scale_err, sync_pulse, clock_sync_fault;
  logic [15:0] scaled_value;
  logic [15:0] last_val = 16'h0;
  mst_fmt_t curr_fmt, gnd_fmt, pwr_fmt;
  logic [TD_WORDS-1:0][15:0] clock_time;
  logic [63:0] td;
  mst_meas_t m;
  int n_mismatch = 0;
  int num_checks = 0;
  int seed = 32'h700e;

  always #25 clk = ~clk;

  mst_core #(.HAS_SEC_EXT(1'b1), .SUP_CYCLES(20)) i_dut (.clk(clk),
    .rst_b(rst_b), .meas_valid(meas_valid), .meas_in(meas_in),
    .scale_index(scale_index), .nom_volt_c(nom_volt_c),
    .nom_curr_c(nom_curr_c), .gnd_rating_c(gnd_rating_c),
    .direct_mode(direct_mode), .req(req), .rsp(rsp),
    .scaled_valid(scaled_valid), .scaled_value(scaled_value),
    .scale_err(scale_err), .curr_fmt(curr_fmt), .gnd_fmt(gnd_fmt),
    .pwr_fmt(pwr_fmt), .sync_pulse(sync_pulse), .clock_time(clock_time),
    .clock_sync_fault(clock_sync_fault));

  mst_master i_mst (.clk(clk), .req(req), .rsp(rsp));

  task automatic check(input string what, input logic [63:0] seen, exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // factor and type per index, truncation toward zero, then clamp
  function automatic logic [15:0] exp_scale(input logic [3:0] i,
    input mst_meas_t v);
    longint f;
    longint x;
    f = (i == 4'h5) ? 1000 : (i == 4'h6) ? 100 :
      (i > 4'h6) ? 10 ** (i - 4'h7) : 10 ** i;
    x = (i == 4'h5 || i > 4'h6) ? v.secondary :
      (i == 4'h6) ? v.percent : v.primary;
    x = x * f / 10000 + ZERO_OFFSET;
    if (x > 32767) x = 32767;
    if (x < -32768) x = -32768;
    return x[15:0];
  endfunction

  task automatic meas(input logic [3:0] i, input mst_meas_t v);
    @(negedge clk);
    scale_index = i;
    meas_in = v;
    meas_valid = 1'b1;
    @(negedge clk);
    meas_valid = 1'b0;
    if (i <= IDX_LAST_EXT) last_val = exp_scale(i, v);
    check("scaled_valid", scaled_valid, 1'b1);
    check("scale_err", scale_err, i > IDX_LAST_EXT);
    check("scaled_value", scaled_value, last_val);
  endtask

  task automatic fmt(input logic [23:0] v, c, input logic [31:0] g,
    input logic [5:0] ec, eg, ep);
    @(negedge clk);
    nom_volt_c = v;
    nom_curr_c = c;
    gnd_rating_c = g;
    repeat (2) @(negedge clk);
    check("curr_fmt", curr_fmt, ec);
    check("gnd_fmt", gnd_fmt, eg);
    check("pwr_fmt", pwr_fmt, ep);
  endtask

  task automatic refuse(input logic w, b, mu, input logic [2:0] s, c);
    i_mst.xfer(w, b, mu, s, c, {48'h0, TRIG_CMD}, r);
    check("refused", {r.valid, r.exc}, {1'b1, EXC_ILLEGAL_ADDR});
    check("no sync", sync_pulse, 1'b0);
  endtask

  // watchdog sized well above the about 180 cycles of the tests
  initial
  begin
    repeat (3000) @(posedge clk);
    n_mismatch++;
    $display("BAD watchdog expired");
    wrap_up();
  end

  initial
  begin
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    // walk case, clamp at both ends, then every index and random values
    meas(4'h2, {32'sd123456, 32'sd0, 32'sd0}); // two digits, factor 100
    meas(4'h4, {32'sh7FFF_FFFF, 32'sd0, 32'sd0});
    meas(4'h4, {-32'sh7FFF_FFFF, 32'sd0, 32'sd0});
    for (int k = 0; k < 48; k++)
    begin
      m = {$random(seed) >>> 4, $random(seed) >>> 4, $random(seed) >>> 4};
      meas((k < 16) ? k[3:0] : 4'($random(seed)), m);
    end
    // band edges: 100.00 A against 100.01 A, 1.00 A ground, 10 kA
    fmt(24'd100, 24'd10000, 32'd100, {4'h0, 2'd1}, {4'hD, 2'd0},
      {4'h3, 2'd0});
    fmt(24'd1200, 24'd10001, 32'd101, {4'h0, 2'd0}, {4'h0, 2'd2},
      {4'h6, 2'd2});
    fmt(24'd100, 24'd5000, 32'd5000, {4'h0, 2'd1}, {4'h0, 2'd1},
      {4'h3, 2'd1});
    fmt(24'd1200, 24'd500000, 32'd2000000, {4'h3, 2'd2}, {4'h3, 2'd1},
      {4'h6, 2'd0});
    fmt(24'd60000, 24'd1000000, 32'd1000000, {4'h3, 2'd2},
      {4'h3, 2'd2}, {4'h9, 2'd1});
    // 500 A bands and 10 MW band, then 1000.00 A edge and 1 GW band
    fmt(24'd1200, 24'd50000, 32'd50000, {4'h0, 2'd0}, {4'h0, 2'd0},
      {4'h6, 2'd1});
    fmt(24'd60000, 24'd100000, 32'd1000000, {4'h0, 2'd0},
      {4'h3, 2'd2}, {4'h9, 2'd2});
    // trigger mode: stage words one by one, nothing applied yet
    td = {$random(seed), $random(seed)};
    for (int k = 0; k < TD_WORDS; k++)
    begin
      i_mst.xfer(1'b1, k[0], 1'b0, k[2:0], 3'd1, {48'h0, td[k*16+:16]}, r);
      check("stage exc", {r.valid, r.exc}, {1'b1, EXC_NONE});
    end
    check("not applied", clock_time, 64'h0);
    // multi write of words 2 and 3 replaces the staged upper half
    td[63:32] = $random(seed);
    i_mst.xfer(1'b1, 1'b0, 1'b1, 3'd2, 3'd2, {32'h0, td[63:32]}, r);
    check("multi stage", clock_time, 64'h0);
    i_mst.xfer(1'b0, 1'b0, 1'b1, 3'd0, 3'd4, 64'h0, r);
    check("readback", r.data, td);
    i_mst.xfer(1'b0, 1'b0, 1'b0, TRIG_IDX, 3'd1, 64'h0, r);
    check("trig read", r.data[0], TRIG_READ_VAL);
    i_mst.xfer(1'b1, 1'b0, 1'b0, TRIG_IDX, 3'd1, {48'h0, TRIG_CMD}, r);
    check("addressed trig", sync_pulse, 1'b0);
    check("fault before", clock_sync_fault, 1'b1);
    i_mst.xfer(1'b1, 1'b1, 1'b0, TRIG_IDX, 3'd1, {48'h0, 16'h1234}, r);
    check("other trig", sync_pulse, 1'b0);
    i_mst.xfer(1'b0, 1'b0, 1'b0, TRIG_IDX, 3'd1, 64'h0, r);
    check("trig reread", r.data[0], TRIG_READ_VAL);
    i_mst.xfer(1'b1, 1'b1, 1'b0, TRIG_IDX, 3'd1, {48'h0, TRIG_CMD}, r);
    check("trig pulse", sync_pulse, 1'b1);
    check("trig time", clock_time, td);
    check("fault cleared", clock_sync_fault, 1'b0);
    // counter reaches zero 20 edges after the sync, fault one edge later
    repeat (20) @(negedge clk);
    check("fault early", clock_sync_fault, 1'b0);
    repeat (1) @(negedge clk);
    check("fault late", clock_sync_fault, 1'b1);
    // direct mode: partial or non-broadcast writes and trigger accesses are refused
    direct_mode = 1'b1;
    refuse(1'b1, 1'b1, 1'b1, 3'd0, 3'd2);
    refuse(1'b1, 1'b1, 1'b0, 3'd1, 3'd1);
    refuse(1'b0, 1'b0, 1'b0, TRIG_IDX, 3'd1);
    refuse(1'b1, 1'b1, 1'b0, TRIG_IDX, 3'd1);
    refuse(1'b1, 1'b0, 1'b1, TD_FIRST_IDX, 3'd4);
    td = {$random(seed), $random(seed)};
    i_mst.xfer(1'b1, 1'b1, 1'b1, TD_FIRST_IDX, 3'd4, td, r);
    check("direct exc", r.exc, EXC_NONE);
    check("direct pulse", sync_pulse, 1'b1);
    check("direct time", clock_time, td);
    check("direct fault", clock_sync_fault, 1'b0);
    wrap_up();
  end
endmodule // test_meas_scaling_time_sync
